// ---- shared/att_defs.vh ----
// att_defs.vh: constants of the address translation block
`ifndef ATT_DEFS_VH
`define ATT_DEFS_VH
// ****************************************************************
// widths
// ****************************************************************
`define ATT_TAGW 36
`define ATT_DATW 32
`define ATT_CTXW 44
`define ATT_WAYS 4
// ****************************************************************
// per-thread context layout: base in [39:0]
// ****************************************************************
`define ATT_C_BASE 39:0
`define ATT_C_PG 40
`define ATT_C_PAE 41
`define ATT_C_PSE 42
`define ATT_C_LMA 43
// ****************************************************************
// cached entry layout
// ****************************************************************
`define ATT_D_FRM 27:0
`define ATT_D_NX 28
`define ATT_D_WR 29
`define ATT_D_MT 30
`define ATT_D_PDE 31
// ****************************************************************
// page-table entry fields and address slices
// ****************************************************************
`define ATT_E_P 0
`define ATT_E_RW 1
`define ATT_E_PCD 4
`define ATT_E_PS 7
`define ATT_E_NX 63
`define ATT_E_FRM 39:12
`define ATT_E_LFRM 39:21
`define ATT_FRM_LG 27:9
`define ATT_SM_OFF 11:0
`define ATT_LG_OFF 20:0
`define ATT_HALF_SEL 2
`define ATT_SM_TAG(a) (a[47:12])
`define ATT_LG_TAG(a) ({9'h000, a[47:21]})
// ****************************************************************
// memory types, levels, address masks, array shapes
// ****************************************************************
`define ATT_MT_UC 1'b0
`define ATT_MT_WB 1'b1
`define ATT_LV_4 3'h4
`define ATT_LV_3 3'h3
`define ATT_LV_2 3'h2
`define ATT_LV_1 3'h1
`define ATT_MASK32 40'h00_ffff_ffff
`define ATT_MASK36 40'h0f_ffff_ffff
`define ATT_MASK40 40'hff_ffff_ffff
`define ATT_DSM_SETS 16
`define ATT_DSM_SETW 4
`define ATT_DLG_SETS 2
`define ATT_DLG_SETW 1
`define ATT_ITL_SETS 8
`define ATT_ITL_SETW 3
`define ATT_L2_SETS 16
`define ATT_L2_SETW 4
`endif

// ---- rtl/att_tlb_array.v ----
// att_tlb_array.v: one 4-way set associative translation store
`timescale 1ns/1ps
`default_nettype none
`include "att_defs.vh"
module att_tlb_array #(
	parameter SETS = 16,
	parameter SETW = 4
) (
	input wire mclk,
	input wire rstn,
	input wire lk_en,
	input wire [`ATT_TAGW-1:0] lk_tag,
	input wire [3:0] lk_share,
	output reg hit_r,
	output reg [`ATT_DATW-1:0] data_r,
	input wire fill_en,
	input wire [`ATT_TAGW-1:0] fill_tag,
	input wire [1:0] fill_tid,
	input wire [`ATT_DATW-1:0] fill_data,
	input wire inv_en,
	input wire [`ATT_TAGW-1:0] inv_tag,
	input wire fl_en,
	input wire [1:0] fl_tid
);
localparam N = SETS * `ATT_WAYS;
reg [`ATT_TAGW-1:0] tag_m [0:N-1];
reg [`ATT_DATW-1:0] dat_m [0:N-1];
reg [1:0] tid_m [0:N-1];
reg [1:0] rr_m [0:SETS-1];
reg [N-1:0] vld_r;
reg [N-1:0] vld_nxt;
reg hit_nxt;
reg [`ATT_DATW-1:0] data_nxt;
integer i;
integer j;
integer k;
integer r;
wire [SETW-1:0] lk_set = lk_tag[SETW-1:0];
wire [SETW-1:0] fi_set = fill_tag[SETW-1:0];
wire [SETW+1:0] fi_idx = {fi_set, rr_m[fi_set]};
// ****************************************************************
// lookup, only entries of threads sharing the context match
// ****************************************************************
always @* begin
	hit_nxt = 1'b0;
	data_nxt = {`ATT_DATW{1'b0}};
	k = 0;
	for (i = 0; i < `ATT_WAYS; i = i + 1) begin
		k = lk_set * `ATT_WAYS + i;
		if (vld_r[k] && tag_m[k] == lk_tag && lk_share[tid_m[k]]) begin
			hit_nxt = 1'b1;
			data_nxt = dat_m[k];
		end
	end
end
// ****************************************************************
// invalidate by address, flush by thread, then fill
// ****************************************************************
always @* begin
	vld_nxt = vld_r;
	for (j = 0; j < N; j = j + 1) begin
		if ((fl_en && tid_m[j] == fl_tid) ||
		    (inv_en && tag_m[j] == inv_tag))
			vld_nxt[j] = 1'b0;
	end
	if (fill_en)
		vld_nxt[fi_idx] = 1'b1;
end
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		vld_r <= {N{1'b0}};
		hit_r <= 1'b0;
		data_r <= {`ATT_DATW{1'b0}};
		for (r = 0; r < SETS; r = r + 1)
			rr_m[r] <= 2'h0;
	end else begin
		vld_r <= vld_nxt;
		hit_r <= lk_en & hit_nxt;
		data_r <= data_nxt;
		if (fill_en)
			rr_m[fi_set] <= rr_m[fi_set] + 2'h1;
	end
end
// storage needs no reset, valid bits guard it
always @(posedge mclk) begin
	if (fill_en) begin
		tag_m[fi_idx] <= fill_tag;
		dat_m[fi_idx] <= fill_data;
		tid_m[fi_idx] <= fill_tid;
	end
end
endmodule // att_tlb_array
`default_nettype wire

// ---- rtl/att_ctx.v ----
// att_ctx.v: paging context register of one hardware thread
`timescale 1ns/1ps
`default_nettype none
`include "att_defs.vh"
module att_ctx #(
	parameter TID = 0
) (
	input wire mclk,
	input wire rstn,
	input wire wr,
	input wire [1:0] wr_tid,
	input wire [`ATT_CTXW-1:0] wr_val,
	output reg [`ATT_CTXW-1:0] ctx_r,
	output wire chg
);
localparam [1:0] MY_TID = TID[1:0];
wire sel = wr && (wr_tid == MY_TID);
// only a real change flushes, rewriting the same value is free
assign chg = sel && (wr_val != ctx_r);
always @(posedge mclk or negedge rstn) begin
	if (!rstn)
		ctx_r <= {`ATT_CTXW{1'b0}};
	else if (sel)
		ctx_r <= wr_val;
end
endmodule // att_ctx
`default_nettype wire

// ---- rtl/att_translate.v ----
// att_translate.v: translation buffers and page walker for one core
// ****************************************************************
// What this block does
// R01: 32, 36 or 40 bit physical addresses
// R02: only 4 KB and 2 MB pages
// R03: fetch from execute-disabled page faults
// R04: no global entries kept across switches
// R05: full miss walks four levels in long mode, three with PAE, two otherwise
// R06: single page invalidate clears every level
// R07: small and large pages mix freely
// R08: software keeps small entries under large consistent
// R09: data buffer: 64 small, 8 large, 4-way
// R10: instruction buffer: 32 small pages only
// R11: second level: 64 entries, large or directory
// R12: share entries only across identical contexts
// R13: every entry tagged with owning thread
// R14: four threads, each with own context
// R15: only uncacheable and write-back types
// R16: faults reported, nothing filled by the faulting step
// R17: changed context makes own entries stale
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "att_defs.vh"
module att_translate (
	input wire mclk,
	input wire rstn,
	input wire ctx_wr,
	input wire [1:0] ctx_thread,
	input wire [39:0] ctx_base,
	input wire paging_enable,
	input wire address_extension_enable,
	input wire page_size_extension,
	input wire long_mode_active,
	input wire req_valid,
	input wire [1:0] req_thread,
	input wire req_fetch,
	input wire req_write,
	input wire [47:0] req_lin,
	output reg req_ready_r,
	output reg rsp_valid_r,
	output reg [1:0] rsp_thread_r,
	output reg [39:0] rsp_pa_r,
	output reg rsp_fault_r,
	output reg rsp_mtype_r,
	output reg rsp_large_r,
	output reg [3:0] page_fault_r,
	output reg mem_rd_r,
	output reg [39:0] mem_addr_r,
	input wire mem_rvalid,
	input wire [63:0] mem_rdata,
	input wire single_page_invalidate,
	input wire [47:0] inv_lin
);
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_LOOK = 3'h2;
localparam [2:0] ST_WALK = 3'h4;
reg [2:0] st_r;
reg [1:0] thr_r;
reg fetch_r;
reg write_r;
reg [47:0] lin_r;
reg [2:0] lvl_r;
reg [27:0] tbl_r;
reg nx_r;
reg wr_r;
reg stale_r;
// ****************************************************************
// per-thread paging context
// ****************************************************************
wire [`ATT_CTXW-1:0] ctx_w [0:3];
wire [3:0] chg_w;
wire [3:0] share_w;
wire [`ATT_CTXW-1:0] ctx_new = {long_mode_active, page_size_extension,
	address_extension_enable, paging_enable, ctx_base};
genvar g;
generate
	for (g = 0; g < 4; g = g + 1) begin : g_ctx
		att_ctx #(.TID(g)) u_ctx ( // [R14]
			.mclk(mclk),
			.rstn(rstn),
			.wr(ctx_wr),
			.wr_tid(ctx_thread),
			.wr_val(ctx_new),
			.ctx_r(ctx_w[g]),
			.chg(chg_w[g])
		);
		// every field of the context must agree to share
		assign share_w[g] = (ctx_w[g] == ctx_w[req_thread]); // [R12]
	end
endgenerate
wire [`ATT_CTXW-1:0] rq_ctx = ctx_w[req_thread];
wire [`ATT_CTXW-1:0] cx = ctx_w[thr_r];
wire c_pg = cx[`ATT_C_PG];
wire c_pae = cx[`ATT_C_PAE];
wire c_lma = cx[`ATT_C_LMA];
wire leg = ~c_pae & ~c_lma;
wire [47:0] rq_lin = rq_ctx[`ATT_C_LMA] ? req_lin :
	{16'h0000, req_lin[31:0]};
wire st_idle = (st_r == ST_IDLE);
wire take = st_idle & req_valid;
wire lk_en = take & rq_ctx[`ATT_C_PG];
// a flush or invalidate racing a walk must not let it refill
wire stale_now = stale_r | single_page_invalidate | chg_w[thr_r]; // [R17]
// the global bit is never looked at, so a switch drops all entries of the switched thread
wire fl_en = |chg_w; // [R04] [R17]
// ****************************************************************
// translation stores
// ****************************************************************
wire ds_hit;
wire dl_hit;
wire it_hit;
wire l2_hit;
wire [`ATT_DATW-1:0] ds_dat;
wire [`ATT_DATW-1:0] dl_dat;
wire [`ATT_DATW-1:0] it_dat;
wire [`ATT_DATW-1:0] l2_dat;
reg f_ds;
reg f_dl;
reg f_it;
reg f_l2;
reg [`ATT_DATW-1:0] f_l2_dat;
reg fin;
reg flt;
reg lrg;
reg [27:0] frm;
reg fnx;
reg fwr;
reg fmt;
reg go_walk;
reg [2:0] n_lvl;
reg [27:0] n_tbl;
reg n_nx;
reg n_wr;
wire [`ATT_DATW-1:0] f_l1_dat = {1'b0, fmt, fwr, fnx, frm};
wire [`ATT_TAGW-1:0] rq_sm = `ATT_SM_TAG(rq_lin);
wire [`ATT_TAGW-1:0] rq_lg = `ATT_LG_TAG(rq_lin);
wire [`ATT_TAGW-1:0] sm_tag = `ATT_SM_TAG(lin_r);
wire [`ATT_TAGW-1:0] lg_tag = `ATT_LG_TAG(lin_r);
wire [`ATT_TAGW-1:0] iv_sm = `ATT_SM_TAG(inv_lin);
wire [`ATT_TAGW-1:0] iv_lg = `ATT_LG_TAG(inv_lin);
// small and large stores are probed together, no region rules
att_tlb_array #(
	.SETS(`ATT_DSM_SETS),
	.SETW(`ATT_DSM_SETW)
) u_dsm ( // [R09] [R07]
	.mclk(mclk),
	.rstn(rstn),
	.lk_en(lk_en),
	.lk_tag(rq_sm),
	.lk_share(share_w),
	.hit_r(ds_hit),
	.data_r(ds_dat),
	.fill_en(f_ds),
	.fill_tag(sm_tag),
	.fill_tid(thr_r),
	.fill_data(f_l1_dat),
	.inv_en(single_page_invalidate),
	.inv_tag(iv_sm),
	.fl_en(fl_en),
	.fl_tid(ctx_thread)
);
att_tlb_array #(
	.SETS(`ATT_DLG_SETS),
	.SETW(`ATT_DLG_SETW)
) u_dlg ( // [R09] [R07]
	.mclk(mclk),
	.rstn(rstn),
	.lk_en(lk_en),
	.lk_tag(rq_lg),
	.lk_share(share_w),
	.hit_r(dl_hit),
	.data_r(dl_dat),
	.fill_en(f_dl),
	.fill_tag(lg_tag),
	.fill_tid(thr_r),
	.fill_data(f_l1_dat),
	.inv_en(single_page_invalidate),
	.inv_tag(iv_lg),
	.fl_en(fl_en),
	.fl_tid(ctx_thread)
);
att_tlb_array #(
	.SETS(`ATT_ITL_SETS),
	.SETW(`ATT_ITL_SETW)
) u_itl ( // [R10]
	.mclk(mclk),
	.rstn(rstn),
	.lk_en(lk_en),
	.lk_tag(rq_sm),
	.lk_share(share_w),
	.hit_r(it_hit),
	.data_r(it_dat),
	.fill_en(f_it),
	.fill_tag(sm_tag),
	.fill_tid(thr_r),
	.fill_data(f_l1_dat),
	.inv_en(single_page_invalidate),
	.inv_tag(iv_sm),
	.fl_en(fl_en),
	.fl_tid(ctx_thread)
);
att_tlb_array #(
	.SETS(`ATT_L2_SETS),
	.SETW(`ATT_L2_SETW)
) u_l2 ( // [R11]
	.mclk(mclk),
	.rstn(rstn),
	.lk_en(lk_en),
	.lk_tag(rq_lg),
	.lk_share(share_w),
	.hit_r(l2_hit),
	.data_r(l2_dat),
	.fill_en(f_l2),
	.fill_tag(lg_tag),
	.fill_tid(thr_r), // [R13]
	.fill_data(f_l2_dat),
	.inv_en(single_page_invalidate), // [R06]
	.inv_tag(iv_lg),
	.fl_en(fl_en),
	.fl_tid(ctx_thread)
);
// ****************************************************************
// walk addressing and entry decode
// ****************************************************************
function [39:0] walk_addr;
	input [2:0] lv;
	input [27:0] tb;
	input [47:0] ln;
	input lg;
	reg [8:0] ix;
	begin
		case (lv)
		`ATT_LV_4: ix = ln[47:39];
		`ATT_LV_3: ix = ln[38:30];
		`ATT_LV_2: ix = ln[29:21];
		default: ix = ln[20:12];
		endcase
		// legacy tables hold 4-byte entries with 10-bit indices
		if (lg)
			walk_addr = {tb, (lv == `ATT_LV_2) ? ln[31:22] : ln[21:12],
				2'h0};
		else
			walk_addr = {tb, ix, 3'h0};
	end
endfunction
wire [31:0] ent_half = mem_addr_r[`ATT_HALF_SEL] ? mem_rdata[63:32] :
	mem_rdata[31:0];
wire [63:0] ent = leg ? {32'h0000_0000, ent_half} : mem_rdata;
wire ent_nx = ent[`ATT_E_NX] & ~leg;
// legacy 4 MB pages are not translated; only 2 MB leaves exist
wire ent_leaf = (lvl_r == `ATT_LV_1) ||
	(lvl_r == `ATT_LV_2 && ent[`ATT_E_PS] && !leg); // [R02]
// write-through, combining and protect collapse onto write-back
wire ent_mt = ent[`ATT_E_PCD] ? `ATT_MT_UC : `ATT_MT_WB; // [R15]
wire l1_hit = fetch_r ? it_hit : (ds_hit | dl_hit);
wire [`ATT_DATW-1:0] l1_dat = fetch_r ? it_dat :
	(ds_hit ? ds_dat : dl_dat);
wire l1_large = ~fetch_r & ~ds_hit;
// ****************************************************************
// lookup result, walk step and fill decisions
// ****************************************************************
always @* begin
	fin = 1'b0;
	flt = 1'b0;
	lrg = 1'b0;
	frm = 28'h0;
	fnx = 1'b0;
	fwr = 1'b1;
	fmt = `ATT_MT_WB;
	go_walk = 1'b0;
	n_lvl = lvl_r;
	n_tbl = tbl_r;
	n_nx = nx_r;
	n_wr = wr_r;
	f_ds = 1'b0;
	f_dl = 1'b0;
	f_it = 1'b0;
	f_l2 = 1'b0;
	f_l2_dat = {`ATT_DATW{1'b0}};
	case (st_r)
	ST_LOOK: begin
		if (!c_pg) begin
			fin = 1'b1;
			frm = lin_r[`ATT_E_FRM];
		end else if (l1_hit && !stale_now) begin
			fin = 1'b1;
			frm = l1_dat[`ATT_D_FRM];
			fnx = l1_dat[`ATT_D_NX];
			fwr = l1_dat[`ATT_D_WR];
			fmt = l1_dat[`ATT_D_MT];
			lrg = l1_large;
		end else if (l2_hit && !l2_dat[`ATT_D_PDE] && !stale_now) begin
			fin = 1'b1;
			frm = l2_dat[`ATT_D_FRM];
			fnx = l2_dat[`ATT_D_NX];
			fwr = l2_dat[`ATT_D_WR];
			fmt = l2_dat[`ATT_D_MT];
			lrg = 1'b1;
			f_dl = ~fetch_r; // [R10]
		end else begin
			go_walk = 1'b1;
			if (l2_hit && !stale_now) begin
				// cached directory entry skips to the last level
				n_lvl = `ATT_LV_1; // [R11]
				n_tbl = l2_dat[`ATT_D_FRM];
				n_nx = l2_dat[`ATT_D_NX];
				n_wr = l2_dat[`ATT_D_WR];
			end else begin
				n_lvl = c_lma ? `ATT_LV_4 :
					(c_pae ? `ATT_LV_3 : `ATT_LV_2); // [R05]
				n_tbl = cx[`ATT_E_FRM];
				n_nx = 1'b0;
				n_wr = 1'b1;
			end
		end
	end
	ST_WALK: begin
		if (mem_rvalid) begin
			if (!ent[`ATT_E_P]) begin
				fin = 1'b1;
				flt = 1'b1; // [R16]
			end else if (ent_leaf) begin
				fin = 1'b1;
				lrg = (lvl_r != `ATT_LV_1); // [R02]
				frm = lrg ? {ent[`ATT_E_LFRM], 9'h000} : ent[`ATT_E_FRM];
				fnx = nx_r | ent_nx;
				fwr = wr_r & ent[`ATT_E_RW];
				fmt = ent_mt;
				f_it = fetch_r & ~lrg; // [R10]
				f_ds = ~fetch_r & ~lrg;
				f_dl = ~fetch_r & lrg;
				f_l2 = lrg;
				f_l2_dat = {1'b0, ent_mt, fwr, fnx, frm};
			end else begin
				go_walk = 1'b1; // [R05]
				n_lvl = lvl_r - 3'h1;
				n_tbl = ent[`ATT_E_FRM];
				n_nx = nx_r | ent_nx;
				n_wr = wr_r & ent[`ATT_E_RW];
				f_l2 = (lvl_r == `ATT_LV_2); // [R11]
				f_l2_dat = {1'b1, `ATT_MT_WB, n_wr, n_nx, n_tbl};
			end
		end
	end
	default: begin
	end
	endcase
	if (fin && !flt)
		flt = (fetch_r & fnx) | (write_r & ~fwr); // [R03] [R16]
	if (flt || stale_now) begin
		f_ds = 1'b0; // [R16] [R17]
		f_dl = 1'b0;
		f_it = 1'b0;
		f_l2 = 1'b0;
	end
end
wire [39:0] pa_full = lrg ? {frm[`ATT_FRM_LG], lin_r[`ATT_LG_OFF]} :
	{frm, lin_r[`ATT_SM_OFF]};
wire [39:0] pa_mask = !c_pg ? `ATT_MASK32 :
	(c_lma ? `ATT_MASK40 : (c_pae ? `ATT_MASK36 : `ATT_MASK32)); // [R01]
// ****************************************************************
// sequencer and registered outputs
// ****************************************************************
always @(posedge mclk or negedge rstn) begin
	if (!rstn) begin
		st_r <= ST_IDLE;
		req_ready_r <= 1'b1;
		rsp_valid_r <= 1'b0;
		rsp_thread_r <= 2'h0;
		rsp_pa_r <= 40'h00_0000_0000;
		rsp_fault_r <= 1'b0;
		rsp_mtype_r <= `ATT_MT_WB;
		rsp_large_r <= 1'b0;
		page_fault_r <= 4'h0;
		mem_rd_r <= 1'b0;
		mem_addr_r <= 40'h00_0000_0000;
		thr_r <= 2'h0;
		fetch_r <= 1'b0;
		write_r <= 1'b0;
		lin_r <= 48'h0000_0000_0000;
		lvl_r <= `ATT_LV_4;
		tbl_r <= 28'h0;
		nx_r <= 1'b0;
		wr_r <= 1'b1;
		stale_r <= 1'b0;
	end else begin
		rsp_valid_r <= 1'b0;
		page_fault_r <= 4'h0;
		mem_rd_r <= 1'b0;
		if (take)
			stale_r <= single_page_invalidate | chg_w[req_thread];
		else
			stale_r <= stale_now; // [R17]
		case (st_r)
		ST_IDLE: begin
			if (req_valid) begin
				thr_r <= req_thread;
				fetch_r <= req_fetch;
				write_r <= req_write & ~req_fetch;
				lin_r <= rq_lin;
				req_ready_r <= 1'b0;
				st_r <= ST_LOOK;
			end
		end
		ST_LOOK, ST_WALK: begin
			if (fin) begin
				rsp_valid_r <= 1'b1;
				rsp_thread_r <= thr_r;
				rsp_fault_r <= flt;
				rsp_pa_r <= flt ? 40'h00_0000_0000 : (pa_full & pa_mask);
				rsp_mtype_r <= fmt;
				rsp_large_r <= lrg;
				page_fault_r <= flt ? (4'h1 << thr_r) : 4'h0; // [R16]
				req_ready_r <= 1'b1;
				st_r <= ST_IDLE;
			end else if (go_walk) begin
				mem_rd_r <= 1'b1;
				mem_addr_r <= walk_addr(n_lvl, n_tbl, lin_r, leg);
				lvl_r <= n_lvl;
				tbl_r <= n_tbl;
				nx_r <= n_nx;
				wr_r <= n_wr;
				st_r <= ST_WALK;
			end
		end
		default: begin
			st_r <= ST_IDLE;
			req_ready_r <= 1'b1;
		end
		endcase
	end
end
endmodule // att_translate
`default_nettype wire

// ---- tb/att_translate_assertions.sv ----
// att_translate_assertions.sv: checks of the translation block
`timescale 1ns/1ps
`default_nettype none
module att_translate_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_ready_r,
	input wire logic rsp_valid_r,
	input wire logic [1:0] rsp_thread_r,
	input wire logic [39:0] rsp_pa_r,
	input wire logic rsp_fault_r,
	input wire logic [3:0] page_fault_r,
	input wire logic mem_rd_r,
	input wire logic mem_rvalid
);
	// ****************************************************************
	// helper state
	// ****************************************************************
	logic pend_r;
	logic [2:0] rdn_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 1'b0;
			rdn_r <= 3'h0;
		end else begin
			if (mem_rd_r)
				pend_r <= 1'b1;
			else if (mem_rvalid)
				pend_r <= 1'b0;
			// saturates: a runaway walk cannot wrap
			if (req_valid && req_ready_r)
				rdn_r <= 3'h0;
			else if (mem_rd_r && rdn_r != 3'h7)
				rdn_r <= rdn_r + 3'h1;
		end
	end
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence take_s; req_valid && req_ready_r; endsequence
	sequence look_s; !req_ready_r && !rsp_valid_r && !mem_rd_r; endsequence
	sequence step_s; mem_rd_r || rsp_valid_r; endsequence
	lookup_cycle_a: assert property (take_s |=> look_s)
		else $error("noisy lookup");
	first_step_a: assert property (take_s ##1 look_s |=> step_s)
		else $error("no step after lookup");
	walk_step_a: assert property (pend_r && mem_rvalid |=>
		mem_rd_r != rsp_valid_r)
		else $error("walk stalled");
	one_read_a: assert property (pend_r |-> !mem_rd_r)
		else $error("two reads outstanding");
	four_level_a: assert property (mem_rd_r |-> rdn_r < 3'h4)
		else $error("walk too long");
	fault_flag_a: assert property (rsp_valid_r && rsp_fault_r |->
		page_fault_r == (4'h1 << rsp_thread_r) && rsp_pa_r == 40'h0)
		else $error("fault flag wrong");
	stray_flag_a: assert property (page_fault_r != 4'h0 |->
		rsp_valid_r && rsp_fault_r)
		else $error("stray fault flag");
	ok_flag_a: assert property (rsp_valid_r && !rsp_fault_r |-> page_fault_r == 4'h0)
		else $error("fault flag on good answer");
	answer_pulse_a: assert property (rsp_valid_r |-> req_ready_r ##1 !rsp_valid_r)
		else $error("answer not a pulse");
	ready_drop_a: assert property ($fell(req_ready_r) |-> $past(req_valid))
		else $error("ready fell unasked");
endmodule // att_translate_chk
`default_nettype wire

// ---- tb/att_ptmem.sv ----
// att_ptmem.sv: page-table memory model
`timescale 1ns/1ps
`default_nettype none
module att_ptmem (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic mem_rd_r,
	input wire logic [39:0] mem_addr_r,
	output logic mem_rvalid,
	output logic [63:0] mem_rdata
);
	// ****************************************************************
	// bench fills it; absent words are not present
	// ****************************************************************
	logic [63:0] mem [logic [36:0]];
	int lat = 1;
	int cnt;
	logic [36:0] adr_r;
	logic [63:0] last_r;
	function automatic logic [63:0] rd(input logic [36:0] a);
		return mem.exists(a) ? mem[a] : 64'h0;
	endfunction
	// idle data lines show the last word inverted
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			adr_r <= 37'h0;
			last_r <= 64'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 64'hffff_ffff_ffff_ffff;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~last_r;
			if (mem_rd_r) begin
				cnt <= lat;
				adr_r <= mem_addr_r[39:3];
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				mem_rvalid <= 1'b1;
				mem_rdata <= rd(adr_r);
				last_r <= rd(adr_r);
			end
		end
	end
endmodule // att_ptmem
`default_nettype wire

// ---- tb/att_translate_bench.sv ----
// att_translate_bench.sv: bench of the translation block
`timescale 1ns/1ps
`default_nettype none
module att_translate_bench;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic mclk, rstn, ctx_wr, paging_enable, address_extension_enable;
	logic page_size_extension, long_mode_active, req_valid, req_fetch;
	logic req_write, req_ready_r, rsp_valid_r, rsp_fault_r, rsp_mtype_r;
	logic rsp_large_r, mem_rd_r, mem_rvalid, single_page_invalidate;
	logic [1:0] ctx_thread, req_thread, rsp_thread_r, r_th;
	logic [39:0] ctx_base, rsp_pa_r, mem_addr_r, r_pa;
	logic [47:0] req_lin, inv_lin;
	logic [3:0] page_fault_r, r_pf;
	logic [63:0] mem_rdata;
	logic r_flt, r_mt, r_lg;
	int r_lat, rd_cnt, err_count, samples_checked, cyc;
	localparam logic [47:0] LA = 48'h0000_0040_1234;
	localparam logic [47:0] LB = 48'h0000_007f_fabc;
	localparam logic [39:0] B0 = 40'h00_0001_0000;
	att_translate u_dut (.mclk, .rstn, .ctx_wr, .ctx_thread, .ctx_base,
		.paging_enable, .address_extension_enable, .page_size_extension,
		.long_mode_active, .req_valid, .req_thread, .req_fetch, .req_write,
		.req_lin, .req_ready_r, .rsp_valid_r, .rsp_thread_r, .rsp_pa_r,
		.rsp_fault_r, .rsp_mtype_r, .rsp_large_r, .page_fault_r, .mem_rd_r,
		.mem_addr_r, .mem_rvalid, .mem_rdata, .single_page_invalidate,
		.inv_lin);
	att_ptmem u_mem (.mclk, .rstn, .mem_rd_r, .mem_addr_r, .mem_rvalid,
		.mem_rdata);
	// ****************************************************************
	// clock, timeout, read counting
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (mem_rd_r === 1'b1)
			rd_cnt++;
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task put(input logic [39:0] a, input logic [63:0] v);
		u_mem.mem[a[39:3]] = v;
	endtask
	// one table page per level above the base
	task map(input logic [39:0] b, input logic [47:0] a, input logic [63:0] leaf,
		input logic lg, lm);
		logic [39:0] p;
		p = b;
		if (lm) begin
			put(p + {28'h0, a[47:39], 3'h0}, {24'h0, p + 40'h1003});
			p = p + 40'h1000;
		end
		put(p + {28'h0, a[38:30], 3'h0}, {24'h0, p + 40'h1003});
		put(p + 40'h1000 + {28'h0, a[29:21], 3'h0},
			lg ? leaf : {24'h0, p + 40'h2003});
		if (!lg)
			put(p + 40'h2000 + {28'h0, a[20:12], 3'h0}, leaf);
	endtask
	task ctx(input logic [1:0] t, input logic [39:0] b, input logic e, x, s, l);
		@(posedge mclk);
		ctx_wr <= 1'b1;
		ctx_thread <= t;
		ctx_base <= b;
		paging_enable <= e;
		address_extension_enable <= x;
		page_size_extension <= s;
		long_mode_active <= l;
		@(posedge mclk);
		ctx_wr <= 1'b0;
	endtask
	task inval(input logic [47:0] a);
		@(posedge mclk);
		single_page_invalidate <= 1'b1;
		inv_lin <= a;
		@(posedge mclk);
		single_page_invalidate <= 1'b0;
	endtask
	// hold request until ready is sampled
	task xlate(input logic [1:0] t, input logic f, w, input logic [47:0] a);
		@(posedge mclk);
		rd_cnt = 0;
		req_valid <= 1'b1;
		req_thread <= t;
		req_fetch <= f;
		req_write <= w;
		req_lin <= a;
		do
			@(posedge mclk);
		while (req_ready_r !== 1'b1);
		req_valid <= 1'b0;
		r_lat = 0;
		do begin
			@(negedge mclk);
			r_lat++;
		end while (rsp_valid_r !== 1'b1 && r_lat < 400);
		r_pa = rsp_pa_r;
		r_flt = rsp_fault_r;
		r_mt = rsp_mtype_r;
		r_lg = rsp_large_r;
		r_pf = page_fault_r;
		r_th = rsp_thread_r;
	endtask
	task res(input logic [39:0] pa, input logic flt, mt, lg, input int rd);
		chk("thread", r_th, req_thread);
		chk("fault", r_flt, flt);
		chk("flags", r_pf, flt ? 4'h1 << req_thread : 4'h0);
		chk("address", r_pa, flt ? 40'h0 : pa);
		if (!flt) begin
			chk("mtype", r_mt, mt);
			chk("large", r_lg, lg);
		end
		if (rd >= 0)
			chk("reads", rd_cnt, rd);
	endtask
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		{rstn, ctx_wr, paging_enable, address_extension_enable} = 4'h0;
		{page_size_extension, long_mode_active, req_valid, req_fetch} = 4'h0;
		{req_write, single_page_invalidate, ctx_thread, req_thread} = 6'h0;
		{ctx_base, req_lin, inv_lin} = 136'h0;
		repeat (10) @(posedge mclk);
		chk("ready in reset", req_ready_r, 1'b1);
		chk("type in reset", rsp_mtype_r, 1'b1);
		rstn <= 1'b1;
		xlate(2'h2, 1'b0, 1'b0, 48'hffff_1234_5678);
		res(40'h00_1234_5678, 1'b0, 1'b1, 1'b0, 0);
		chk("off latency", r_lat, 2);
		$display("paging off done");
		ctx(2'h0, B0, 1'b1, 1'b1, 1'b0, 1'b1);
		ctx(2'h1, B0, 1'b1, 1'b1, 1'b0, 1'b1);
		map(B0, LA, 64'h00ab_cdef_5103, 1'b0, 1'b1);
		map(B0, LB, 64'h0012_3440_0083, 1'b1, 1'b1);
		u_mem.lat = 4;
		xlate(2'h0, 1'b0, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 4);
		u_mem.lat = 1;
		xlate(2'h0, 1'b0, 1'b1, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 0);
		chk("hit latency", r_lat, 2);
		xlate(2'h1, 1'b0, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 0);
		xlate(2'h0, 1'b1, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 1);
		xlate(2'h0, 1'b1, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 0);
		xlate(2'h0, 1'b0, 1'b0, LB);
		res(40'h12_345f_fabc, 1'b0, 1'b1, 1'b1, 3);
		xlate(2'h0, 1'b1, 1'b0, LB);
		res(40'h12_345f_fabc, 1'b0, 1'b1, 1'b1, 0);
		$display("walks done");
		map(B0, 48'h40_2000, 64'h8000_0000_0000_6003, 1'b0, 1'b1);
		map(B0, 48'h40_3000, 64'h7001, 1'b0, 1'b1);
		map(B0, 48'h40_4000, 64'h8013, 1'b0, 1'b1);
		xlate(2'h0, 1'b1, 1'b0, 48'h40_2000);
		res(40'h0, 1'b1, 1'b1, 1'b0, -1);
		xlate(2'h0, 1'b1, 1'b0, 48'h40_2000);
		chk("refetch walks", rd_cnt != 0, 1'b1);
		xlate(2'h0, 1'b0, 1'b0, 48'h40_2000);
		res(40'h6000, 1'b0, 1'b1, 1'b0, -1);
		xlate(2'h0, 1'b0, 1'b1, 48'h40_3000);
		res(40'h0, 1'b1, 1'b1, 1'b0, -1);
		xlate(2'h0, 1'b0, 1'b0, 48'h40_3000);
		res(40'h7000, 1'b0, 1'b1, 1'b0, -1);
		xlate(2'h0, 1'b0, 1'b0, 48'h40_5000);
		res(40'h0, 1'b1, 1'b1, 1'b0, -1);
		xlate(2'h0, 1'b0, 1'b0, 48'h40_4000);
		res(40'h8000, 1'b0, 1'b0, 1'b0, -1);
		$display("faults done");
		inval(LA);
		xlate(2'h0, 1'b0, 1'b0, LA);
		chk("data walks", rd_cnt != 0, 1'b1);
		xlate(2'h0, 1'b1, 1'b0, LA);
		chk("fetch walks", rd_cnt != 0, 1'b1);
		inval(LB);
		xlate(2'h0, 1'b0, 1'b0, LB);
		chk("large walks", rd_cnt != 0, 1'b1);
		ctx(2'h2, 40'h00_0002_0000, 1'b1, 1'b1, 1'b0, 1'b1);
		map(40'h00_0002_0000, LA, 64'h0056_7860_0083, 1'b1, 1'b1);
		xlate(2'h2, 1'b0, 1'b0, LA);
		res(40'h56_7860_1234, 1'b0, 1'b1, 1'b1, 3);
		xlate(2'h0, 1'b0, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 0);
		ctx(2'h0, B0, 1'b1, 1'b1, 1'b1, 1'b1);
		xlate(2'h0, 1'b0, 1'b0, LA);
		res(40'hab_cdef_5234, 1'b0, 1'b1, 1'b0, 4);
		ctx(2'h3, 40'h00_0003_0000, 1'b1, 1'b1, 1'b0, 1'b0);
		map(40'h00_0003_0000, 48'h4040_1234, 64'h00ab_cdef_5003, 1'b0, 1'b0);
		u_mem.lat = 3;
		xlate(2'h3, 1'b0, 1'b0, 48'h4040_1234);
		res(40'h0b_cdef_5234, 1'b0, 1'b1, 1'b0, 3);
		$display("contexts done");
		end_sim();
	end
endmodule // att_translate_bench
bind att_translate att_translate_chk u_chk (.mclk, .rstn, .req_valid,
	.req_ready_r, .rsp_valid_r, .rsp_thread_r, .rsp_pa_r, .rsp_fault_r,
	.page_fault_r, .mem_rd_r, .mem_rvalid);
`default_nettype wire
